// ### core/drsl_pkg.sv
package drsl_pkg;

    // ==========================================================
    // Clock and timing.
    localparam int unsigned CLOCK_PERIOD_NS = 5;
    localparam int unsigned EEPROM_WRITE_TIME_NS = 10000000;
    localparam int unsigned EEPROM_WRITE_CYCLES = EEPROM_WRITE_TIME_NS / CLOCK_PERIOD_NS;
    localparam int unsigned CONVERSION_FRAME_TIME_NS = 1000000;
    localparam int unsigned CONVERSION_FRAME_CYCLES = CONVERSION_FRAME_TIME_NS / CLOCK_PERIOD_NS;

    // ==========================================================
    // Register map.
    localparam logic [7:0] CONTROL1_ADDR = 8'h03;
    localparam logic [7:0] VOLTAGE_ADDR = 8'h0E;
    localparam logic [7:0] LUT_FIRST_ADDR = 8'h80;
    localparam logic [7:0] LUT_LAST_ADDR = 8'hC7;
    localparam int unsigned UPDATE_MODE_BIT = 0;
    localparam int unsigned ADDER_MODE_BIT = 1;
    localparam logic UPDATE_MODE_RESET = 1'b1;
    localparam logic ADDER_MODE_RESET = 1'b1;
    localparam logic [7:0] VOLTAGE_RESET = 8'h00;

    // ==========================================================
    // Bus framing.
    localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h0A;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam int unsigned PAGE_BITS = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_MEMADDR,
        ST_WRITE,
        ST_READ,
        ST_IGNORE
    } drsl_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } drsl_write_t;

    typedef struct packed {
        logic signed_mode;
        logic [8:0] value;
    } drsl_lut_t;

endpackage

// ### core/drsl_sync.sv
`timescale 1ns/1ps

module drsl_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_check
        $error("Width must be at least one.");
    end

    // ==========================================================
    // Two flip-flops; the first is read only by the second.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stage1 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ### core/drsl_mem.sv
`timescale 1ns/1ps

module drsl_mem #(
    parameter int unsigned ADDR_WIDTH = 8,
    parameter int unsigned DATA_WIDTH = 8
) (
    input wire logic clock,
    input wire logic write_en,
    input wire logic [ADDR_WIDTH-1:0] write_addr,
    input wire logic [DATA_WIDTH-1:0] write_data,
    input wire logic [ADDR_WIDTH-1:0] read_addr_a,
    output logic [DATA_WIDTH-1:0] read_data_a,
    input wire logic [ADDR_WIDTH-1:0] read_addr_b,
    output logic [DATA_WIDTH-1:0] read_data_b
);

    logic [DATA_WIDTH-1:0] cells [0:(1 << ADDR_WIDTH)-1];

    if (ADDR_WIDTH < 1 || ADDR_WIDTH > 16 || DATA_WIDTH < 1) begin : g_check
        $error("Memory size out of range.");
    end

    // ==========================================================
    // One write port and two registered read ports.
    always_ff @(posedge clock) begin
        if (write_en) begin
            cells[write_addr] <= write_data;
        end
        read_data_a <= cells[read_addr_a];
        read_data_b <= cells[read_addr_b];
    end

endmodule

// ### core/drsl_i2c_slave.sv
`timescale 1ns/1ps

// Overview of operation
// - Voltage result register refreshes each frame only while update mode is one.
// - Lookup entries live at 80h to C7h and feed wiper compensation.
// - Entries are unsigned 8-bit, or signed 7-bit when adder mode is set.
// - SDA falling while SCL high starts a transfer.
// - SDA rising while SCL high stops a transfer.
// - A repeated start is accepted mid-transfer and restarts addressing.
// - Master changes SDA with SCL low; device samples on SCL rise.
// - Read bits are driven at the falling SCL edge before their pulse.
// - The byte receiver drives the ninth bit; zero acknowledges.
// - Bytes are eight bits, most significant first, then one acknowledge.
// - On the master's final not-acknowledge the device releases SDA.
// - First byte after start holds 7-bit address and direction bit.
// - Two address pins set two slave address bits.
// - Direction zero writes, one reads; pins low give 50h and 51h.
// - A mismatched address makes the device ignore the bus until start.
// - The second byte of a write loads the address pointer.
// - Written data applies on its eighth bit, before acknowledge; EEPROM commits after stop.
// - A write ended by repeated start commits nothing and adds no delay.
// - Writes wrap inside an 8-byte page; the last eight bytes survive.
// - While EEPROM writes after stop, the slave address is not acknowledged.
// - Reads start at the pointer and wrap from FFh to 00h.
// - Update mode zero halts temperature and voltage result updates.
module drsl_i2c_slave
    import drsl_pkg::*;
#(
    parameter int unsigned EEPROM_CYCLES = drsl_pkg::EEPROM_WRITE_CYCLES,
    parameter int unsigned FRAME_CYCLES = drsl_pkg::CONVERSION_FRAME_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin_low,
    input wire logic address_select_pin_high,
    input wire logic [7:0] voltage_sample,
    output logic temperature_update_enable,
    input wire logic [6:0] lut_index,
    output drsl_pkg::drsl_lut_t lut_out,
    output drsl_pkg::drsl_write_t wiper_write,
    output logic eeprom_commit,
    output logic eeprom_busy
);

    import drsl_pkg::*;

    if (EEPROM_CYCLES < 1 || FRAME_CYCLES < 1) begin : g_check
        $error("Cycle counts must be at least one.");
    end

    // ==========================================================
    // Link domain on SCL.
    logic link_bit;
    logic link_drive;
    logic drive_low;
    logic link_active;

    always_ff @(posedge scl) begin
        link_bit <= sda_in;
    end

    always_ff @(negedge scl) begin
        link_drive <= drive_low;
    end

    assign sda_out = 1'b0;
    assign sda_oe = link_drive & link_active;

    // ==========================================================
    // Crossing into the system clock.
    logic [4:0] sync_q;
    logic scl_s, sda_s, bit_s, pin_low_s, pin_high_s;
    logic scl_d, sda_d;
    logic scl_rise, bit_tick;
    logic start_cond, stop_cond;

    drsl_sync #(.WIDTH(5), .RESET_VALUE(5'h07)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in({address_select_pin_high, address_select_pin_low, link_bit, sda_in, scl}),
        .sync_out(sync_q)
    );

    assign {pin_high_s, pin_low_s, bit_s, sda_s, scl_s} = sync_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            bit_tick <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            bit_tick <= scl_rise;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // Protocol state.
    drsl_state_t state;
    logic [3:0] bit_count;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] pointer;
    logic read_dir;
    logic pending;
    logic update_mode;
    logic adder_mode;
    logic [7:0] voltage;
    logic [7:0] mem_rdata;
    logic [7:0] lut_rdata;
    logic [7:0] read_byte;
    logic [7:0] full_byte;
    logic [7:0] lut_addr;
    logic addr_match;
    logic byte_done;
    logic ack_done;
    logic write_take;
    logic [31:0] busy_count;
    logic [31:0] frame_count;
    logic frame_tick;

    assign full_byte = {shift_in[6:0], bit_s};
    assign addr_match = (full_byte[7:1] == {SLAVE_ADDR_FIXED, pin_high_s, pin_low_s});
    assign byte_done = bit_tick && bit_count == LAST_DATA_BIT;
    assign ack_done = bit_tick && bit_count == ACK_BIT;
    assign write_take = byte_done && state == ST_WRITE;
    assign eeprom_busy = busy_count != 32'h0;

    always_comb begin
        if (pointer == VOLTAGE_ADDR) begin
            read_byte = voltage;
        end else if (pointer == CONTROL1_ADDR) begin
            read_byte = {6'h00, adder_mode, update_mode};
        end else begin
            read_byte = mem_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= ST_IDLE;
            bit_count <= 4'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            read_dir <= 1'b0;
            drive_low <= 1'b0;
            link_active <= 1'b0;
        end else if (start_cond) begin
            state <= ST_ADDR;
            bit_count <= 4'h0;
            drive_low <= 1'b0;
            link_active <= 1'b1;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            bit_count <= 4'h0;
            drive_low <= 1'b0;
            link_active <= 1'b0;
        end else if (bit_tick) begin
            case (state)
                ST_ADDR, ST_MEMADDR, ST_WRITE: begin
                    if (bit_count < ACK_BIT) begin
                        shift_in <= full_byte;
                        bit_count <= bit_count + 4'h1;
                    end
                    if (bit_count == LAST_DATA_BIT) begin
                        if (state == ST_ADDR && (!addr_match || eeprom_busy)) begin
                            state <= ST_IGNORE;
                            drive_low <= 1'b0;
                        end else begin
                            drive_low <= 1'b1;
                        end
                        if (state == ST_ADDR) begin
                            read_dir <= full_byte[0];
                        end
                    end
                    if (bit_count == ACK_BIT) begin
                        bit_count <= 4'h0;
                        if (state == ST_ADDR && read_dir) begin
                            state <= ST_READ;
                            shift_out <= read_byte;
                            drive_low <= ~read_byte[7];
                        end else begin
                            drive_low <= 1'b0;
                            if (state == ST_ADDR) begin
                                state <= ST_MEMADDR;
                            end else begin
                                state <= ST_WRITE;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (bit_count < LAST_DATA_BIT) begin
                        shift_out <= {shift_out[6:0], 1'b0};
                        drive_low <= ~shift_out[6];
                        bit_count <= bit_count + 4'h1;
                    end else if (bit_count == LAST_DATA_BIT) begin
                        drive_low <= 1'b0;
                        bit_count <= ACK_BIT;
                    end else if (!bit_s) begin
                        shift_out <= read_byte;
                        drive_low <= ~read_byte[7];
                        bit_count <= 4'h0;
                    end else begin
                        state <= ST_IGNORE;
                        drive_low <= 1'b0;
                        bit_count <= 4'h0;
                    end
                end
                ST_IGNORE: begin
                    drive_low <= 1'b0;
                end
                default: begin
                    drive_low <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Address pointer.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pointer <= 8'h00;
        end else if (!start_cond && !stop_cond) begin
            if (byte_done && state == ST_MEMADDR) begin
                pointer <= full_byte;
            end else if (write_take) begin
                pointer <= {pointer[7:PAGE_BITS], pointer[PAGE_BITS-1:0] + 3'h1};
            end else if (byte_done && state == ST_READ) begin
                pointer <= pointer + 8'h01;
            end
        end
    end

    // ==========================================================
    // Applied writes, control bits and EEPROM commit.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wiper_write <= '0;
            update_mode <= UPDATE_MODE_RESET;
            adder_mode <= ADDER_MODE_RESET;
        end else begin
            wiper_write.valid <= write_take && !start_cond && !stop_cond;
            wiper_write.addr <= pointer;
            wiper_write.data <= full_byte;
            if (write_take && !start_cond && !stop_cond && pointer == CONTROL1_ADDR) begin
                update_mode <= full_byte[UPDATE_MODE_BIT];
                adder_mode <= full_byte[ADDER_MODE_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pending <= 1'b0;
            eeprom_commit <= 1'b0;
            busy_count <= 32'h0;
        end else begin
            eeprom_commit <= stop_cond && pending;
            if (start_cond || stop_cond) begin
                pending <= 1'b0;
            end else if (write_take) begin
                pending <= 1'b1;
            end
            if (stop_cond && pending) begin
                busy_count <= EEPROM_CYCLES;
            end else if (eeprom_busy) begin
                busy_count <= busy_count - 32'h1;
            end
        end
    end

    // ==========================================================
    // Register storage and lookup port.
    assign lut_addr = (lut_index < 7'h48) ? LUT_FIRST_ADDR + {1'b0, lut_index} : LUT_LAST_ADDR;

    drsl_mem #(.ADDR_WIDTH(8), .DATA_WIDTH(8)) u_mem (
        .clock(clock),
        .write_en(wiper_write.valid),
        .write_addr(wiper_write.addr),
        .write_data(wiper_write.data),
        .read_addr_a(pointer),
        .read_data_a(mem_rdata),
        .read_addr_b(lut_addr),
        .read_data_b(lut_rdata)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            lut_out <= '0;
        end else begin
            lut_out.signed_mode <= adder_mode;
            if (adder_mode) begin
                lut_out.value <= {{2{lut_rdata[6]}}, lut_rdata[6:0]};
            end else begin
                lut_out.value <= {1'b0, lut_rdata};
            end
        end
    end

    // ==========================================================
    // Conversion frame and voltage result.
    assign frame_tick = frame_count == 32'h0;
    assign temperature_update_enable = update_mode;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            frame_count <= 32'h0;
            voltage <= VOLTAGE_RESET;
        end else begin
            frame_count <= frame_tick ? FRAME_CYCLES - 1 : frame_count - 32'h1;
            if (frame_tick && update_mode) begin
                voltage <= voltage_sample;
            end
        end
    end

    // ==========================================================
    // Checks.
    sequence s_addr_byte_seen;
        byte_done && state == ST_ADDR;
    endsequence

    sequence s_stop_with_data;
        stop_cond && pending;
    endsequence

    property p_start_addr;
        @(posedge clock) disable iff (!nrst) start_cond |=> state == ST_ADDR && bit_count == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("Start not taken.");

    property p_stop_idle;
        @(posedge clock) disable iff (!nrst) stop_cond |=> state == ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("Stop not taken.");

    property p_match_ack;
        @(posedge clock) disable iff (!nrst)
            s_addr_byte_seen and (addr_match && !eeprom_busy && !start_cond && !stop_cond)
            |=> drive_low && state == ST_ADDR;
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("Own address not acknowledged.");

    property p_busy_nack;
        @(posedge clock) disable iff (!nrst)
            s_addr_byte_seen and (eeprom_busy && !start_cond && !stop_cond)
            |=> state == ST_IGNORE && !drive_low;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("Address acknowledged while busy.");

    property p_ignore_quiet;
        @(posedge clock) disable iff (!nrst) state == ST_IGNORE |=> !drive_low;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("Drive while ignoring.");

    property p_page_wrap;
        @(posedge clock) disable iff (!nrst) write_take && !start_cond && !stop_cond
            |=> pointer[7:3] == $past(pointer[7:3]) && pointer[2:0] == $past(pointer[2:0]) + 3'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("Page wrap broken.");

    property p_read_wrap;
        @(posedge clock) disable iff (!nrst)
            byte_done && state == ST_READ && pointer == 8'hFF && !start_cond && !stop_cond
            |=> pointer == 8'h00;
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("Read wrap broken.");

    property p_commit;
        @(posedge clock) disable iff (!nrst) s_stop_with_data |=> eeprom_commit ##1 eeprom_busy[*3];
    endproperty
    a_commit: assert property (p_commit) else $error("No commit after stop.");

    property p_restart_no_commit;
        @(posedge clock) disable iff (!nrst) start_cond |=> !pending ##1 !eeprom_commit;
    endproperty
    a_restart_no_commit: assert property (p_restart_no_commit) else $error("Commit on restart.");

    property p_voltage_hold;
        @(posedge clock) disable iff (!nrst) !update_mode |=> $stable(voltage);
    endproperty
    a_voltage_hold: assert property (p_voltage_hold) else $error("Voltage changed while halted.");

    property p_voltage_load;
        @(posedge clock) disable iff (!nrst) frame_tick && update_mode |=> voltage == $past(voltage_sample);
    endproperty
    a_voltage_load: assert property (p_voltage_load) else $error("Voltage not refreshed.");

endmodule

// ### verif/drsl_i2c_master.sv
`timescale 1ns/1ps

// ==========================================================
// Bus master that makes every SCL pulse and releases SDA to the pull-up.
module drsl_i2c_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_xfer(input logic b, output logic r);
        sda_low = !b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
        #40;
    endtask

    task automatic start();
        #1.3 sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask

    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(nack, r);
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import drsl_pkg::*;
    // ==========================================================
    // Signals and reference model.
    localparam int EE = 2000;
    localparam int FR = 50;
    localparam int LIMIT = 80000;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic pin_lo = 1'b0;
    logic pin_hi = 1'b0;
    logic [7:0] vsamp = 8'h5A;
    logic [6:0] lut_index = 7'h00;
    logic temp_en;
    logic eeprom_commit;
    logic eeprom_busy;
    drsl_lut_t lut_out;
    drsl_write_t wiper_write;
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [15:0] wq [$];
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int commits = 0;
    wire sda = !(sda_low || (sda_oe && !sda_out));

    drsl_i2c_master i_drsl_i2c_master (.scl(scl), .sda_low(sda_low), .sda(sda));
    drsl_i2c_slave #(.EEPROM_CYCLES(EE), .FRAME_CYCLES(FR)) i_drsl_i2c_slave (
        .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_select_pin_low(pin_lo), .address_select_pin_high(pin_hi),
        .voltage_sample(vsamp), .temperature_update_enable(temp_en), .lut_index(lut_index),
        .lut_out(lut_out), .wiper_write(wiper_write), .eeprom_commit(eeprom_commit),
        .eeprom_busy(eeprom_busy)
    );

    always #2.5 clock = ~clock;

    always @(negedge clock) begin
        cycles++;
        if (wiper_write.valid === 1'b1) begin
            wq.push_back({wiper_write.addr, wiper_write.data});
        end
        if (eeprom_commit === 1'b1) begin
            commits++;
        end
        if (cycles == LIMIT) begin
            fails++;
            end_sim();
        end
    end

    // ==========================================================
    // Comparisons and transactions.
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk10(input drsl_lut_t got, input drsl_lut_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_busy();
        repeat (10) @(negedge clock);
        for (int i = 0; i < EE + 100 && eeprom_busy !== 1'b0; i++) begin
            @(negedge clock);
        end
        chk1(eeprom_busy, 1'b0);
    endtask

    task automatic sel(input logic [7:0] b, input logic exp);
        logic a;
        i_drsl_i2c_master.start();
        i_drsl_i2c_master.send(b, a);
        chk1(a, exp);
    endtask

    task automatic wr(input logic [7:0] ma, input int n, input int d0, input bit stp);
        logic a;
        logic [7:0] d;
        logic [15:0] w;
        sel(8'h50, 1'b0);
        i_drsl_i2c_master.send(ma, a);
        chk1(a, 1'b0);
        ptr = ma;
        for (int i = 0; i < n; i++) begin
            d = (d0 < 0) ? 8'($urandom) : 8'(d0);
            i_drsl_i2c_master.send(d, a);
            chk1(a, 1'b0);
            mem[ptr] = d;
            chk8(8'(wq.size()), 8'h01);
            w = wq.pop_front();
            chk8(w[15:8], ptr);
            chk8(w[7:0], d);
            ptr = {ptr[7:3], ptr[2:0] + 3'h1};
        end
        if (stp) begin
            i_drsl_i2c_master.stop();
        end
    endtask

    task automatic rd(input logic [7:0] ma, input int n);
        logic a;
        logic [7:0] d;
        sel(8'h50, 1'b0);
        i_drsl_i2c_master.send(ma, a);
        chk1(a, 1'b0);
        sel(8'h51, 1'b0);
        ptr = ma;
        for (int i = 0; i < n; i++) begin
            i_drsl_i2c_master.recv(1'(i == n - 1), d);
            chk8(d, mem[ptr]);
            ptr = ptr + 8'h01;
        end
        i_drsl_i2c_master.stop();
    endtask

    task automatic lut_scan(input logic adder);
        drsl_lut_t e;
        logic [7:0] m;
        for (int k = 0; k < 9; k++) begin
            @(negedge clock) lut_index = (k < 8) ? 7'(k) : 7'h7F;
            repeat (3) @(negedge clock);
            m = (k < 8) ? mem[8'(128 + k)] : mem[8'hC7];
            e.signed_mode = adder;
            e.value = adder ? {m[6], m[6], m[6:0]} : {1'b0, m};
            chk10(lut_out, e);
        end
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        logic a;
        void'($urandom(7));
        repeat (3) @(posedge clock);
        @(negedge clock) nrst = 1'b1;
        repeat (FR + 5) @(negedge clock);
        mem[8'h03] = 8'h03;
        mem[8'h0E] = vsamp;
        chk1(temp_en, 1'b1);
        for (int p = 0; p < 4; p++) begin
            @(negedge clock) {pin_hi, pin_lo} = 2'(p);
            repeat (10) @(negedge clock);
            sel(8'h50 | 8'(p << 1), 1'b0);
            sel(8'h50 | 8'(((p + 1) % 4) << 1), 1'b1);
            i_drsl_i2c_master.send(8'h80, a);
            chk1(a, 1'b1);
            i_drsl_i2c_master.stop();
        end
        @(negedge clock) {pin_hi, pin_lo} = 2'b00;
        repeat (10) @(negedge clock);
        wr(8'h80, 10, -1, 1'b1);
        repeat (10) @(negedge clock);
        chk8(8'(commits), 8'h01);
        chk1(eeprom_busy, 1'b1);
        sel(8'h50, 1'b1);
        i_drsl_i2c_master.stop();
        wait_busy();
        rd(8'h80, 8);
        wr(8'hFE, 2, -1, 1'b0);
        wr(8'h00, 1, -1, 1'b0);
        rd(8'hFE, 3);
        chk8(8'(commits), 8'h01);
        chk1(eeprom_busy, 1'b0);
        rd(8'h0E, 1);
        @(negedge clock) vsamp = 8'hA5;
        wr(8'h03, 1, 8'h02, 1'b1);
        mem[8'h0E] = 8'hA5;
        wait_busy();
        chk1(temp_en, 1'b0);
        @(negedge clock) vsamp = 8'h3C;
        repeat (3 * FR) @(negedge clock);
        rd(8'h0E, 1);
        wr(8'hC7, 1, -1, 1'b0);
        rd(8'h03, 1);
        lut_scan(1'b1);
        wr(8'h03, 1, 8'h01, 1'b1);
        wait_busy();
        lut_scan(1'b0);
        end_sim();
    end
endmodule
